/* fsp_pix_source.sv */
// Pixel source model: streams one 324-pixel frame per start pulse.
// Assumes the block's valid/ready pixel port; odd positions carry hi.
`timescale 1ns/10ps

module fsp_pix_source (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic slow_in,
  input wire logic [5:0] hi_in,
  input wire logic [5:0] lo_in,
  input wire logic ready_in,
  output logic valid_out,
  output fsp_pkg::fsp_pix_t pix_out,
  output logic busy_out
);
  logic [8:0] pos_reg;
  logic [8:0] pos_next;

  assign pos_next = pos_reg + 9'h001;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_reg <= '0;
      valid_out <= 1'b0;
      pix_out <= '0;
      busy_out <= 1'b0;
    end else if (valid_out && !ready_in) begin
      // Stalled: hold pixel and qualifiers
    end else if (start_in && !busy_out) begin
      busy_out <= 1'b1;
      pos_reg <= 9'h001;
      valid_out <= 1'b1;
      pix_out <= '{1'b1, hi_in};
    end else if (busy_out) begin
      if (valid_out && (pos_reg == 9'h144 || slow_in)) begin
        // Idle data toggles so a stale sample is never mistaken
        busy_out <= (pos_reg != 9'h144);
        valid_out <= 1'b0;
        pix_out <= ~pix_out;
      end else begin
        pos_reg <= pos_next;
        valid_out <= 1'b1;
        pix_out <= '{1'b0, pos_next[0] ? hi_in : lo_in};
      end
    end
  end

endmodule : fsp_pix_source

/* fsp_pkg.sv */
// Constants and carrier types for the frame statistics and pixel dump block.
// Assumes one 25 MHz core clock and 8-bit registers at 7-bit addresses.
package fsp_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PIX_W = 6;
  localparam int SUM_W = 15;
  localparam int EXP_W = 16;

  localparam logic [ADDR_W-1:0] OFS_CONFIG = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_BRIGHT = 7'h05;
  localparam logic [ADDR_W-1:0] OFS_DARK = 7'h06;
  localparam logic [ADDR_W-1:0] OFS_TOTAL = 7'h07;
  localparam logic [ADDR_W-1:0] OFS_READOUT = 7'h08;
  localparam logic [ADDR_W-1:0] OFS_EXP_HIGH = 7'h09;
  localparam logic [ADDR_W-1:0] OFS_EXP_LOW = 7'h0a;
  localparam logic [ADDR_W-1:0] OFS_ID_COMP = 7'h11;

  localparam int STAY_AWAKE_POS = 0;
  localparam int FIRST_POS = 7;
  localparam int FRESH_POS = 6;
  localparam int SUM_SHIFT = 7;

  localparam logic [PIX_W-1:0] BRIGHT_RESET = 6'h00;
  localparam logic [PIX_W-1:0] DARK_RESET = 6'h3f;
  localparam logic [EXP_W-1:0] EXP_RESET = 16'h0100;
  localparam logic [EXP_W-1:0] EXP_FLOOR = 16'h0010;
  localparam int EXP_STEP_SHIFT = 4;

  // Exposure loop window for the brightest pixel
  localparam logic [PIX_W-1:0] BRIGHT_LOW = 6'h34;
  localparam logic [PIX_W-1:0] BRIGHT_HIGH = 6'h39;

  localparam logic [8:0] PIX_COUNT = 9'h144;
  localparam logic [8:0] PIX_ONE = 9'h001;

  // Cap formula terms: clock rate / 1500 - 3476
  localparam int CAP_DIV = 1500;
  localparam int CAP_SUB = 3476;
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;

  // Idle time before sleep, in frames: one second at 1500 frames/s
  localparam int IDLE_TIME_MS = 1000;
  localparam int FRAMES_PER_S = 1500;
  localparam int IDLE_FRAMES = IDLE_TIME_MS * FRAMES_PER_S / 1000;

  typedef struct packed {
    logic first;
    logic [PIX_W-1:0] level;
  } fsp_pix_t;

endpackage : fsp_pkg

/* fsp_top.sv */
// Frame statistics, auto exposure and one-pixel-per-frame image readout.
// Assumes pixels arrive in frame order, pixel one flagged, on the core
// clock; the serial port front end decodes into the register strobes.
// How it works
// RL1 - Brightest pixel reads six bits, top zero
// RL2 - Darkest pixel six bits, resets to 0x3f
// RL3 - Sum 324 pixels, report sum over 128
// RL4 - Readout write restarts at pixel one
// RL5 - Each valid readout read advances index
// RL6 - Readout: first flag, fresh flag, level
// RL7 - After pixel 324 index wraps to one
// RL8 - Only one pixel captured per frame
// RL9 - Any readout access arms capture, held
// RL10 - Fresh flag only for newly captured sample
// RL11 - First flag set only for pixel one
// RL12 - Controller writes readout, reads 324 valid
// RL13 - Exposure loop keeps brightest mid fifties
// RL14 - Exposure 16 bits, reset 0x0100, two bytes
// RL15 - Controller reads high then low byte
// RL16 - Exposure steps by one sixteenth
// RL17 - Exposure capped at clock/1500 minus 3476
// RL18 - Low nibble holds complemented product id
// RL19 - Config bit zero keeps sensor awake
// RL20 - Statistics update together per frame
`timescale 1ns/10ps

module fsp_top #(
  parameter int CLK_HZ = fsp_pkg::CLK_HZ,
  parameter int IDLE_FRAMES = fsp_pkg::IDLE_FRAMES,
  parameter logic [3:0] PRODUCT_ID = 4'h5  // Arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [fsp_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [fsp_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [fsp_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic pix_valid_in,
  input wire fsp_pkg::fsp_pix_t pix_in,
  output logic pix_ready_out,
  input wire logic motion_in,
  output logic [fsp_pkg::EXP_W-1:0] exposure_out,
  output logic stay_awake_out,
  output logic awake_out
);

  localparam int EXP_CAP_INT = CLK_HZ / fsp_pkg::CAP_DIV - fsp_pkg::CAP_SUB;
  localparam logic [fsp_pkg::EXP_W-1:0] EXP_MAX = EXP_CAP_INT[15:0];

  default clocking chk_cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  initial begin
    if (EXP_CAP_INT <= 32 || EXP_CAP_INT > 65535 || IDLE_FRAMES < 1 ||
        IDLE_FRAMES > 65535) begin
      $error("fsp_top: clock rate or idle count out of range");
    end
  end

  // Step of one sixteenth, never zero so the loop cannot lock up
  function automatic logic [15:0] exp_step(input logic [15:0] v);
    logic [15:0] s;
    s = v >> fsp_pkg::EXP_STEP_SHIFT;
    return (s == 16'h0000) ? 16'h0001 : s;
  endfunction : exp_step

  ////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between the pixel source and the statistics

  fsp_pkg::fsp_pix_t buf_q [2];
  logic [1:0] buf_cnt_reg;
  logic [1:0] buf_cnt_next;
  logic buf_push;
  logic buf_pop;
  logic commit_reg;

  assign buf_push = pix_valid_in && pix_ready_out;
  // Frame commit cycle stalls the drain; the buffer absorbs it
  assign buf_pop = (buf_cnt_reg != 2'h0) && !commit_reg;
  assign buf_cnt_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_cnt_reg <= 2'h0;
      pix_ready_out <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      buf_cnt_reg <= buf_cnt_next;
      pix_ready_out <= (buf_cnt_next != 2'h2);
      if (buf_pop) begin
        buf_q[0] <= (buf_push && buf_cnt_reg == 2'h1) ? pix_in : buf_q[1];
        if (buf_push && buf_cnt_reg == 2'h2) begin
          buf_q[1] <= pix_in;
        end
      end else if (buf_push) begin
        if (buf_cnt_reg == 2'h0) begin
          buf_q[0] <= pix_in;
        end else begin
          buf_q[1] <= pix_in;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame position and running statistics

  logic [8:0] pos_reg;
  logic [8:0] cur_pos;
  logic [5:0] run_max_reg;
  logic [5:0] run_min_reg;
  logic [14:0] run_sum_reg;
  logic [5:0] bright_reg;
  logic [5:0] dark_reg;
  logic [7:0] total_reg;

  assign cur_pos = buf_q[0].first ? fsp_pkg::PIX_ONE : pos_reg + 9'h001;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_reg <= 9'h000;
      run_max_reg <= fsp_pkg::BRIGHT_RESET;
      run_min_reg <= fsp_pkg::DARK_RESET;
      run_sum_reg <= 15'h0000;
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= buf_pop && (cur_pos == fsp_pkg::PIX_COUNT);
      if (buf_pop) begin
        pos_reg <= cur_pos;
        if (cur_pos == fsp_pkg::PIX_ONE) begin  // RL3
          run_max_reg <= buf_q[0].level;
          run_min_reg <= buf_q[0].level;
          run_sum_reg <= {9'h000, buf_q[0].level};
        end else begin
          run_sum_reg <= run_sum_reg + {9'h000, buf_q[0].level};  // RL3
          if (buf_q[0].level > run_max_reg) begin
            run_max_reg <= buf_q[0].level;
          end
          if (buf_q[0].level < run_min_reg) begin
            run_min_reg <= buf_q[0].level;
          end
        end
      end
    end
  end

  // All three published in one cycle from one frame
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bright_reg <= fsp_pkg::BRIGHT_RESET;
      dark_reg <= fsp_pkg::DARK_RESET;  // RL2
      total_reg <= 8'h00;
    end else if (commit_reg) begin  // RL20
      bright_reg <= run_max_reg;
      dark_reg <= run_min_reg;
      total_reg <= run_sum_reg[14:fsp_pkg::SUM_SHIFT];  // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exposure loop

  logic [15:0] step;
  logic [16:0] exp_up;

  assign step = exp_step(exposure_out);
  assign exp_up = {1'b0, exposure_out} + {1'b0, step};

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exposure_out <= fsp_pkg::EXP_RESET;  // RL14
    end else if (commit_reg) begin
      if (run_max_reg > fsp_pkg::BRIGHT_HIGH) begin  // RL13
        if (exposure_out >= fsp_pkg::EXP_FLOOR + step) begin
          exposure_out <= exposure_out - step;  // RL16
        end
      end else if (run_max_reg < fsp_pkg::BRIGHT_LOW) begin
        if (exp_up <= {1'b0, EXP_MAX}) begin  // RL17
          exposure_out <= exp_up[15:0];  // RL16
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel dump engine

  logic [8:0] dump_idx_reg;
  logic [5:0] sample_reg;
  logic fresh_reg;
  logic armed_reg;
  logic hunt_reg;
  logic dump_wr;
  logic dump_rd;
  logic capture;

  assign dump_wr = reg_wr_in && reg_addr_in == fsp_pkg::OFS_READOUT;
  assign dump_rd = reg_rd_in && reg_addr_in == fsp_pkg::OFS_READOUT;
  // Wait for a frame start after arming: the next frame, not this one
  assign capture = armed_reg && buf_pop && cur_pos == dump_idx_reg &&
                   (hunt_reg || cur_pos == fsp_pkg::PIX_ONE);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dump_idx_reg <= fsp_pkg::PIX_ONE;
      sample_reg <= 6'h00;
      fresh_reg <= 1'b0;
      armed_reg <= 1'b0;
      hunt_reg <= 1'b0;
    end else if (capture && !dump_wr) begin
      sample_reg <= buf_q[0].level;
      fresh_reg <= 1'b1;  // RL10
      armed_reg <= 1'b0;  // RL8
    end else if (dump_wr || dump_rd) begin
      armed_reg <= 1'b1;  // RL9
      hunt_reg <= 1'b0;
      fresh_reg <= 1'b0;
      if (dump_wr) begin
        dump_idx_reg <= fsp_pkg::PIX_ONE;  // RL4
      end else if (fresh_reg) begin
        dump_idx_reg <= (dump_idx_reg == fsp_pkg::PIX_COUNT) ?
                        fsp_pkg::PIX_ONE :  // RL7
                        dump_idx_reg + 9'h001;  // RL5
      end
    end else if (armed_reg && buf_pop && cur_pos == fsp_pkg::PIX_ONE) begin
      hunt_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration, sleep timer

  logic [15:0] idle_reg;
  logic motion_seen_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stay_awake_out <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == fsp_pkg::OFS_CONFIG) begin
      stay_awake_out <= reg_wdata_in[fsp_pkg::STAY_AWAKE_POS];  // RL19
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_reg <= 16'h0000;
      motion_seen_reg <= 1'b0;
      awake_out <= 1'b1;
    end else begin
      // New motion wins over the per-frame clear
      motion_seen_reg <= motion_in || (motion_seen_reg && !commit_reg);
      if (commit_reg) begin
        if (motion_seen_reg || motion_in) begin
          idle_reg <= 16'h0000;
        end else if (idle_reg != IDLE_FRAMES[15:0]) begin
          idle_reg <= idle_reg + 16'h0001;
        end
      end
      awake_out <= stay_awake_out || (idle_reg != IDLE_FRAMES[15:0]);  // RL19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read path

  logic [7:0] exp_low_hold_reg;
  logic hold_valid_reg;
  logic [7:0] rd_mux;

  // High byte read freezes the low byte so the pair stays coherent
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exp_low_hold_reg <= 8'h00;
      hold_valid_reg <= 1'b0;
    end else if (reg_rd_in || reg_wr_in) begin
      hold_valid_reg <= reg_rd_in && reg_addr_in == fsp_pkg::OFS_EXP_HIGH;
      exp_low_hold_reg <= exposure_out[7:0];
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_in)
      fsp_pkg::OFS_CONFIG: rd_mux = {7'h00, stay_awake_out};
      fsp_pkg::OFS_BRIGHT: rd_mux = {2'b00, bright_reg};  // RL1
      fsp_pkg::OFS_DARK: rd_mux = {2'b00, dark_reg};  // RL2
      fsp_pkg::OFS_TOTAL: rd_mux = total_reg;
      fsp_pkg::OFS_READOUT:
        rd_mux = {dump_idx_reg == fsp_pkg::PIX_ONE &&
                  (fresh_reg || armed_reg),  // RL11
                  fresh_reg, sample_reg};  // RL6
      fsp_pkg::OFS_EXP_HIGH: rd_mux = exposure_out[15:8];  // RL14
      fsp_pkg::OFS_EXP_LOW:
        rd_mux = hold_valid_reg ? exp_low_hold_reg : exposure_out[7:0];
      fsp_pkg::OFS_ID_COMP: rd_mux = {4'h0, ~PRODUCT_ID};  // RL18
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence readout_wr_s;
    dump_wr;
  endsequence
  sequence restart_s;
    dump_idx_reg == fsp_pkg::PIX_ONE && !fresh_reg && armed_reg;
  endsequence
  bright_top_zero_a: assert property (  // RL1
    reg_rd_in && reg_addr_in == fsp_pkg::OFS_BRIGHT |=>
      reg_rdata_out[7:6] == 2'b00)
    else $error("brightest top bits set");
  stats_together_a: assert property (  // RL20
    commit_reg |=> bright_reg == $past(run_max_reg) &&
                   dark_reg == $past(run_min_reg) && dark_reg <= bright_reg)
    else $error("statistics not from one frame");
  sum_scale_a: assert property (  // RL3
    commit_reg |=> total_reg == $past(run_sum_reg[14:7]))
    else $error("sum not divided by 128");
  dump_restart_a: assert property (readout_wr_s |=> restart_s)  // RL4
    else $error("readout write did not restart");
  dump_advance_a: assert property (  // RL5
    dump_rd && !dump_wr && fresh_reg && dump_idx_reg < fsp_pkg::PIX_COUNT
    |=> dump_idx_reg == $past(dump_idx_reg) + 9'h001)
    else $error("index did not advance");
  dump_wrap_a: assert property (  // RL7
    dump_rd && !dump_wr && fresh_reg && dump_idx_reg == fsp_pkg::PIX_COUNT
    |=> dump_idx_reg == fsp_pkg::PIX_ONE)
    else $error("index did not wrap");
  first_flag_a: assert property (  // RL11
    dump_rd |=> reg_rdata_out[7] == ($past(dump_idx_reg) == 9'h001 &&
                ($past(fresh_reg) || $past(armed_reg))) &&
                reg_rdata_out[6] == $past(fresh_reg))
    else $error("readout flags wrong");
  one_capture_a: assert property (  // RL8
    capture && !dump_wr |=> fresh_reg && !armed_reg)
    else $error("capture did not hold");
  exp_cap_a: assert property (  // RL17
    exposure_out <= EXP_MAX || exposure_out == fsp_pkg::EXP_RESET)
    else $error("exposure above cap");
  exp_step_a: assert property (  // RL16
    exposure_out != $past(exposure_out) |->
      (exposure_out == $past(exposure_out) + exp_step($past(exposure_out)) ||
       exposure_out == $past(exposure_out) - exp_step($past(exposure_out))))
    else $error("exposure step not one sixteenth");
  exp_dir_a: assert property (  // RL13
    commit_reg && run_max_reg > fsp_pkg::BRIGHT_HIGH |=>
      exposure_out <= $past(exposure_out))
    else $error("bright frame raised exposure");
  stay_awake_a: assert property (stay_awake_out [*2] |-> awake_out)  // RL19
    else $error("asleep while forced awake");

endmodule : fsp_top

/* fsp_top_test.sv */
// Self-checking bench for the frame statistics and pixel readout block.
// Assumes the register strobe protocol and a pixel source model.
`timescale 1ns/10ps

module fsp_top_test;
  localparam logic [3:0] PROD_ID = 4'h5;  // Arbitrary value
  // Low rate setting puts the exposure cap at 0x0100, within reach
  localparam int CLK_HZ_TB = 5598000;
  logic clk, rst_n, rd, wr, mot, start, slow, pv, rvalid, prdy;
  logic stay, awake, busy;
  logic [6:0] addr;
  logic [7:0] wd, rdata, d, lvl;
  logic [15:0] expo, e, step, s;
  fsp_pkg::fsp_pix_t px;
  int fails, comparisons, cyc;
  int cap;
  logic [6:0] ra[8] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a,
                        7'h11, 7'h7f};
  logic [7:0] rv[8] = '{8'h00, 8'h3f, 8'h00, 8'h00, 8'h01, 8'h00,
                        {4'h0, ~PROD_ID}, 8'h00};
  logic [5:0] fh[5] = '{6'h3c, 6'h32, 6'h37, 6'h28, 6'h3f};
  logic [5:0] fl[5] = '{6'h03, 6'h0a, 6'h14, 6'h00, 6'h3f};

  fsp_top #(
    .CLK_HZ(CLK_HZ_TB),
    .IDLE_FRAMES(2),
    .PRODUCT_ID(PROD_ID)
  ) dut_u (
    .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pix_valid_in(pv), .pix_in(px), .pix_ready_out(prdy),
    .motion_in(mot), .exposure_out(expo), .stay_awake_out(stay),
    .awake_out(awake)
  );

  fsp_pix_source src_u (
    .clk_in(clk), .rst_n_in(rst_n), .start_in(start), .slow_in(slow),
    .hi_in(fh[0]), .lo_in(fl[0]), .ready_in(prdy), .valid_out(pv),
    .pix_out(px), .busy_out(busy)
  );

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_reg(input logic [6:0] a, output logic [7:0] q);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    // A missing answer strobe turns the data unknown
    q = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask : rd_reg

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic exp_reg(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] q;
    rd_reg(a, q);
    chk({8'h00, q}, {8'h00, v});
  endtask : exp_reg

  task automatic send_frame(input int k);
    @(posedge clk);
    fh[0] <= fh[k];
    fl[0] <= fl[k];
    slow <= k[0];
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    while (busy === 1'b1) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : send_frame

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {rd, wr, start, slow} = '0;
    mot = 1'b1;
    addr = '0;
    wd = '0;
    e = 16'h0100;
    cap = CLK_HZ_TB / fsp_pkg::CAP_DIV - fsp_pkg::CAP_SUB;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      exp_reg(ra[i], rv[i]);
    end
    wr_reg(fsp_pkg::OFS_DARK, 8'h12);
    exp_reg(fsp_pkg::OFS_DARK, 8'h3f);
    wr_reg(fsp_pkg::OFS_CONFIG, 8'hfe);
    exp_reg(fsp_pkg::OFS_CONFIG, 8'h00);
    wr_reg(fsp_pkg::OFS_READOUT, 8'h5a);
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        @(posedge clk) mot <= 1'b0;
      end
      send_frame(k);
      s = 16'(162 * (fh[k] + fl[k]));
      step = ((e >> 4) == 16'h0000) ? 16'h0001 : (e >> 4);
      if (fh[k] > 6'h39 && e - step >= 16'h0010) begin
        e = e - step;
      end else if (fh[k] < 6'h34 && int'(e + step) <= cap) begin
        e = e + step;
      end
      exp_reg(fsp_pkg::OFS_BRIGHT, {2'b00, fh[k]});
      exp_reg(fsp_pkg::OFS_DARK, {2'b00, fl[k]});
      exp_reg(fsp_pkg::OFS_TOTAL, s[14:7]);
      exp_reg(fsp_pkg::OFS_EXP_HIGH, e[15:8]);
      exp_reg(fsp_pkg::OFS_EXP_LOW, e[7:0]);
      chk(expo, e);
      // Frame k yields pixel k+1; odd positions carry the bright level
      lvl = {(k == 0), 1'b1, k[0] ? fl[k] : fh[k]};
      exp_reg(fsp_pkg::OFS_READOUT, lvl);
      rd_reg(fsp_pkg::OFS_READOUT, d);
      chk({14'h0000, d[7:6]}, 16'h0000);
      if (k > 2) begin
        chk({15'h0000, awake}, {15'h0000, k == 3});
      end
    end
    wr_reg(fsp_pkg::OFS_CONFIG, 8'h01);
    exp_reg(fsp_pkg::OFS_CONFIG, 8'h01);
    chk({15'h0000, stay}, 16'h0001);
    chk({15'h0000, awake}, 16'h0001);
    report_and_stop();
  end

endmodule : fsp_top_test
